//--- rtl/caf_filter_ctrl.sv
// APB register block for sixteen CAN acceptance filter controls.
// Assumes APB3 master on mclk_i; filter settings go to the compare logic.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns

// Function
// - Enable bit one makes filter take part
// - Two-bit code picks acceptance mask zero-three
// - Five-bit code picks destination FIFO 0-31
// - Selectors writable only while filter disabled
// - Even filter: enable 7, mask 6:5, FIFO 4:0
// - Odd filter: enable 15, mask 14:13, FIFO 12:8
// - Clear, set, invert aliases at 4/8/C
module caf_filter_ctrl
#(
   parameter int NUM_REGS = 4
)
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [4*NUM_REGS-1:0] filter_active_o,
   output logic [2*4*NUM_REGS-1:0] mask_choice_o,
   output logic [5*4*NUM_REGS-1:0] target_fifo_choice_o
);
   localparam int NF = caf_pkg::CAF_FILTERS_PER_REG * NUM_REGS;
   localparam int FB = caf_pkg::CAF_FILTER_BITS;

   initial
   begin
      if (NUM_REGS != 4)
         $error("caf_filter_ctrl: NUM_REGS must be 4");
   end

   // ==========================================================
   // Address decode
   caf_pkg::caf_apb_req_s req;
   assign req = '{paddr: paddr_i, pwrite: pwrite_i, pwdata: pwdata_i};

   wire logic [15:0] base_addr = {req.paddr[15:4], 4'h0};
   wire logic [3:0] alias_addr = req.paddr[3:0];
   wire logic hit0 = base_addr == caf_pkg::CAF_OFS_CTRL_0_TO_3;
   wire logic hit1 = base_addr == caf_pkg::CAF_OFS_CTRL_4_TO_7;
   wire logic hit2 = base_addr == caf_pkg::CAF_OFS_CTRL_8_TO_11;
   wire logic hit3 = base_addr == caf_pkg::CAF_OFS_CTRL_12_TO_15;
   wire logic [3:0] reg_hit = {hit3, hit2, hit1, hit0};
   wire logic alias_ok = (alias_addr == caf_pkg::CAF_ALIAS_WRITE) || (alias_addr == caf_pkg::CAF_ALIAS_CLR)
                         || (alias_addr == caf_pkg::CAF_ALIAS_SET) || (alias_addr == caf_pkg::CAF_ALIAS_INV);
   wire logic mapped = (|reg_hit) && alias_ok;
   wire logic setup = psel_i && !penable_i;
   // Reads of alias addresses return the plain register
   wire logic acc_wr = psel_i && penable_i && pready_o && req.pwrite && mapped && !pslverr_o;

   caf_pkg::caf_op_e op;
   assign op = (alias_addr == caf_pkg::CAF_ALIAS_CLR) ? caf_pkg::CAF_OP_CLR :
               (alias_addr == caf_pkg::CAF_ALIAS_SET) ? caf_pkg::CAF_OP_SET :
               (alias_addr == caf_pkg::CAF_ALIAS_INV) ? caf_pkg::CAF_OP_INV : caf_pkg::CAF_OP_WRITE;

   // ==========================================================
   // Filter storage
   logic [8*NF-1:0] flat;
   wire logic [1:0] reg_idx = {hit3 | hit2, hit3 | hit1};
   wire logic [31:0] cur_word = flat[32*reg_idx +: 32];
   logic [31:0] new_word;

   always_comb
   begin
      case (op)
         caf_pkg::CAF_OP_CLR: new_word = cur_word & ~req.pwdata;
         caf_pkg::CAF_OP_SET: new_word = cur_word | req.pwdata;
         caf_pkg::CAF_OP_INV: new_word = cur_word ^ req.pwdata;
         default: new_word = req.pwdata;
      endcase
   end

   // Four filter bytes per word: bytes 0/1 low half, 2/3 upper half
   genvar gi;
   generate
      for (gi = 0; gi < NF; gi++)
      begin : g_slot
         localparam int RI = gi / caf_pkg::CAF_FILTERS_PER_REG;
         localparam int BI = gi % caf_pkg::CAF_FILTERS_PER_REG;
         wire logic slot_wr = acc_wr && reg_hit[RI];
         caf_pkg::caf_filter_s fs;

         caf_filter_slot u_slot
         (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .wr_i(slot_wr),
            .new_i(new_word[FB*BI +: FB]),
            .cur_o(flat[FB*gi +: FB])
         );

         assign fs = caf_pkg::caf_filter_s'(flat[FB*gi +: FB]);

         // Outputs registered so compare logic sees flop-driven settings
         always_ff @(posedge mclk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               filter_active_o[gi] <= 1'b0;
               mask_choice_o[2*gi +: 2] <= 2'h0;
               target_fifo_choice_o[5*gi +: 5] <= 5'h00;
            end
            else
            begin
               filter_active_o[gi] <= fs.filter_active_bit;
               mask_choice_o[2*gi +: 2] <= fs.mask_choice;
               target_fifo_choice_o[5*gi +: 5] <= fs.target_fifo_choice;
            end
         end
      end
   endgenerate

   // ==========================================================
   // APB response: no wait states, data and error ready at access
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         pready_o <= setup;
         pslverr_o <= setup && !mapped;
         prdata_o <= (setup && mapped && !req.pwrite) ? cur_word : 32'h0000_0000;
      end
   end

endmodule : caf_filter_ctrl

//--- rtl/caf_filter_slot.sv
// One filter's control byte: enable, mask choice and FIFO choice.
// Assumes the caller has already formed the intended new byte value.
`timescale 1ns/1ns
module caf_filter_slot
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic wr_i,
   input wire logic [7:0] new_i,
   output logic [7:0] cur_o
);
   // ==========================================================
   // Guarded update
   logic [7:0] cur_q;
   logic [7:0] cur_d;
   wire logic locked = cur_q[caf_pkg::CAF_EN_POS];
   wire logic [7:0] guard_mask = locked ? (8'h01 << caf_pkg::CAF_EN_POS) : 8'hff;

   // Selectors frozen while active; the enable bit itself always writable
   assign cur_d = wr_i ? ((new_i & guard_mask) | (cur_q & ~guard_mask)) : cur_q;

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cur_q <= caf_pkg::CAF_RESET_VALUE[7:0];
      else
         cur_q <= cur_d;
   end

   assign cur_o = cur_q;
endmodule : caf_filter_slot

//--- rtl/caf_pkg.sv
// Package for the CAN acceptance filter control block.
// Assumes a 32-bit APB slave and sixteen filters in four registers.
package caf_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] CAF_OFS_CTRL_0_TO_3 = 16'h10c0;
   localparam logic [15:0] CAF_OFS_CTRL_4_TO_7 = 16'h10d0;
   localparam logic [15:0] CAF_OFS_CTRL_8_TO_11 = 16'h10e0;
   localparam logic [15:0] CAF_OFS_CTRL_12_TO_15 = 16'h10f0;
   localparam logic [3:0] CAF_ALIAS_WRITE = 4'h0;
   localparam logic [3:0] CAF_ALIAS_CLR = 4'h4;
   localparam logic [3:0] CAF_ALIAS_SET = 4'h8;
   localparam logic [3:0] CAF_ALIAS_INV = 4'hc;
   localparam logic [31:0] CAF_RESET_VALUE = 32'h0000_0000;

   // ==========================================================
   // Per-filter field layout within its byte
   localparam int CAF_FILTER_BITS = 8;
   localparam int CAF_FILTERS_PER_REG = 4;
   localparam int CAF_EN_POS = 7;
   localparam int CAF_MASK_LSB = 5;
   localparam int CAF_MASK_W = 2;
   localparam int CAF_FIFO_LSB = 0;
   localparam int CAF_FIFO_W = 5;

   typedef enum logic [1:0] {
      CAF_OP_WRITE,
      CAF_OP_CLR,
      CAF_OP_SET,
      CAF_OP_INV
   } caf_op_e;

   typedef struct packed {
      logic filter_active_bit;
      logic [CAF_MASK_W-1:0] mask_choice;
      logic [CAF_FIFO_W-1:0] target_fifo_choice;
   } caf_filter_s;

   typedef struct packed {
      logic [15:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } caf_apb_req_s;

endpackage : caf_pkg

//--- tb/caf_filter_ctrl_assertions.sv
// Checker on the caf_filter_ctrl ports.
// Bound from tb_top; one clock, async low reset.
`timescale 1ns/1ns
module caf_filter_ctrl_assertions
#(
   parameter int NUM_REGS = 4
)
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [4*NUM_REGS-1:0] filter_active_o,
   input wire logic [2*4*NUM_REGS-1:0] mask_choice_o,
   input wire logic [5*4*NUM_REGS-1:0] target_fifo_choice_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   wire wr = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o;
   // ==========================================================
   // Properties
   a_ready_once: assert property (pready_o |-> penable_i && $past(psel_i && !penable_i))
      else $error("pready out of place");
   // Outputs trail the accepted write by two edges: register, then output flop
   a_idle_hold: assert property (!wr |-> ##2 $stable(filter_active_o) && $stable(mask_choice_o))
      else $error("filters moved without write");
   a_mask_lock: assert property (filter_active_o[0] |=> $stable(mask_choice_o[1:0]))
      else $error("mask changed while enabled");
   a_fifo_lock: assert property (filter_active_o[4] |=> $stable(target_fifo_choice_o[24:20]))
      else $error("fifo changed while enabled");
   a_wr_even: assert property (wr && paddr_i == 16'h10c0 |-> ##2 filter_active_o[0] == $past(pwdata_i[7], 2))
      else $error("even enable wrong");
   a_wr_odd: assert property (wr && paddr_i == 16'h10d0 |-> ##2 filter_active_o[5] == $past(pwdata_i[15], 2))
      else $error("odd enable wrong");
   a_set_en: assert property (wr && paddr_i == 16'h10c8 && pwdata_i[7] |-> ##2 filter_active_o[0])
      else $error("set alias failed");
   a_clr_en: assert property (wr && paddr_i == 16'h10c4 && pwdata_i[15] |-> ##2 !filter_active_o[1])
      else $error("clear alias failed");
   a_inv_en: assert property (wr && paddr_i == 16'h10cc && pwdata_i[23] |-> ##2 $changed(filter_active_o[2]))
      else $error("invert alias failed");
   cover property (wr && filter_active_o[0]);
   cover property (pslverr_o);
   cover property (wr && paddr_i == 16'h10cc);
endmodule : caf_filter_ctrl_assertions

//--- tb/tb_top.sv
// Self-checking bench for the filter control registers.
// Drives APB itself; checker bound at the foot.
`timescale 1ns/1ns
module tb_top;
   logic mclk_i = 1'b0;
   logic nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
   logic [15:0] paddr_i, fa;
   logic [31:0] pwdata_i, prdata_o, r, mc;
   logic [79:0] fc;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   always #2 mclk_i = ~mclk_i;
   caf_filter_ctrl dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .filter_active_o(fa), .mask_choice_o(mc), .target_fifo_choice_o(fc));
   // ==========================================================
   // Tasks
   task automatic chk(input string n, input logic [79:0] x, input logic [79:0] g);
      checks++;
      if (g !== x)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask : apb
   task automatic tally_and_finish;
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // Hang guard, far above the 68 cycles used
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 16'h10c0 + 16'(i * 16), 32'h0);
         chk("reset", 32'h0, r);
      end
      apb(1'b1, 16'h10c0, 32'h8a6b_15e3);
      // Filter outputs settle one edge after the access edge
      @(posedge mclk_i);
      chk("fields", {4'h9, 8'h33, 20'h52ea3}, {fa[3:0], mc[7:0], fc[19:0]});
      apb(1'b1, 16'h10c0, 32'h0);
      apb(1'b0, 16'h10c0, 32'h0);
      chk("locked", 32'h0a00_0063, r);
      apb(1'b1, 16'h10c8, 32'h0000_0080);
      apb(1'b1, 16'h10c4, 32'h0000_8080);
      apb(1'b1, 16'h10cc, 32'h0080_001f);
      apb(1'b0, 16'h10cc, 32'h0);
      chk("alias", 32'h0a80_007c, r);
      for (int i = 1; i < 4; i++)
      begin
         apb(1'b1, 16'h10c0 + 16'(i * 16), 32'hffff_ffff);
         apb(1'b0, 16'h10c0 + 16'(i * 16), 32'h0);
         chk("upper", 32'hffff_ffff, r);
      end
      chk("enables", 16'hfff4, fa);
      apb(1'b1, 16'h1000, 32'h0);
      chk("slverr", 1'b1, e);
      chk("masks", 32'hffff_ff03, mc);
      chk("fifo15", 5'h1f, fc[79:75]);
      tally_and_finish();
   end
endmodule : tb_top
bind caf_filter_ctrl caf_filter_ctrl_assertions #(.NUM_REGS(NUM_REGS)) chk_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .filter_active_o(filter_active_o),
   .mask_choice_o(mask_choice_o), .target_fifo_choice_o(target_fifo_choice_o));
